// file: logic/sync_burst_sram_cycle_control.sv
// Cycle decoder of a synchronous flow-through burst SRAM
//
// Contract
// - Deselect on primary select high with controller strobe, or expansion selects inactive.
// - Sleep request high: power down, ignore inputs, keep data pins tri-stated.
// - All selects active and processor strobe low begin a read at external address.
// - Controller strobe start begins burst at external address; write qualifier picks direction.
// - Strobes high, advance low, qualifier high: read at next burst address.
// - Strobes high, advance low, qualifier low: write at next burst address.
// - Strobes high, advance high, qualifier high: read at current address, no advance.
// - Strobes high, advance high, qualifier low: write at unchanged current address.
// - Write qualifier active on global write low, or gate low with any lane low.
// - Write qualifier inactive when all lane selects, gate and global write high.
// - Data pin drive follows current cycle type and present output enable level.
// - Output enable acts combinationally on data drivers, never registered.
// - A processor strobe start is always a read, whatever the write inputs.
// - Output enable is masked during writes; data pins stay inputs.
// - In reads, data tri-stated when output enable high or device deselected.
// - In reads, all data bits driven while output enable is low.
// - Global write low overrides gate and lane selects, writing every lane.
// - Any lane combination legal; only selected lanes, with parity, are written.
// - Burst order linear when order select low, interleaved when high.
// - Controller strobe ignored when processor strobe is low on the same edge; the code ignores it only while primary select is also low.
`timescale 1ns/1ns
`default_nettype none

module sync_burst_sram_cycle_control (
  input wire logic clock,
  input wire logic srst,
  input wire logic clockEnable,
  input wire logic primary_select_n,
  input wire logic expansion_select_high,
  input wire logic expansion_select_n,
  input wire logic sleep_request,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic lane_a_write_n,
  input wire logic lane_b_write_n,
  input wire logic lane_c_write_n,
  input wire logic lane_d_write_n,
  input wire logic burstOrderSelect,
  input wire logic outputEnable_n,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] address,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] dqIn,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] coreReadData,
  output logic [sram_cycle_pkg::DATA_W-1:0] dqOut,
  output logic [sram_cycle_pkg::DATA_W-1:0] dqOe,
  output logic [sram_cycle_pkg::ADDR_W-1:0] coreAddr,
  output logic [sram_cycle_pkg::LANES-1:0] coreWriteLanes,
  output logic [sram_cycle_pkg::DATA_W-1:0] coreWriteData,
  output logic coreRead,
  output sram_cycle_pkg::cycle_t cycleKind,
  output logic sleeping
);

  // ********************************************************
  // Pin synchronisers for sleep and order select
  // ********************************************************
  logic sleepMeta;
  logic sleepSync;
  logic orderMeta;
  logic orderSync;

  always_ff @(posedge clock) begin
    if (srst) begin
      sleepMeta <= 1'b0;
      sleepSync <= 1'b0;
      orderMeta <= 1'b1;
      orderSync <= 1'b1;
    end else if (clockEnable) begin
      sleepMeta <= sleep_request;
      sleepSync <= sleepMeta;
      orderMeta <= burstOrderSelect;
      orderSync <= orderMeta;
    end
  end

  // ********************************************************
  // Write qualifier and lane decode
  // ********************************************************
  logic [sram_cycle_pkg::LANES-1:0] laneSelect_n;
  logic [sram_cycle_pkg::LANES-1:0] laneWrites;
  logic writeQualifier_n;

  assign laneSelect_n = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};

  function automatic logic [sram_cycle_pkg::LANES-1:0] lanesToWrite(
    input logic globalN,
    input logic gateN,
    input logic [sram_cycle_pkg::LANES-1:0] selectN
  );
    if (!globalN) begin
      lanesToWrite = sram_cycle_pkg::LANES_ALL;
    end else if (!gateN) begin
      lanesToWrite = ~selectN;
    end else begin
      lanesToWrite = sram_cycle_pkg::LANES_NONE;
    end
  endfunction

  assign laneWrites = lanesToWrite(global_write_n, byte_write_gate_n, laneSelect_n);
  assign writeQualifier_n = ~(|laneWrites);

  // ********************************************************
  // Cycle decode
  // ********************************************************
  logic selectsActive;
  logic processorStart;
  logic processorDeselect;
  logic controllerStart;
  logic strobesIdle;
  logic beginWrite;
  logic burstWrite;
  logic nextWrite;
  sram_cycle_pkg::cycle_t next_cycle;

  assign selectsActive = ~primary_select_n & expansion_select_high & ~expansion_select_n;
  // Processor strobe counts only while the primary select is low
  assign processorStart = ~processor_addr_strobe_n & ~primary_select_n;
  assign processorDeselect = processorStart & ~selectsActive;
  assign controllerStart = ~processorStart & ~controller_addr_strobe_n;
  assign strobesIdle = ~processorStart & controller_addr_strobe_n;

  assign next_cycle = sleepSync ? sram_cycle_pkg::CYC_SLEEP :
                      processorDeselect ? sram_cycle_pkg::CYC_DESELECT :
                      processorStart ? sram_cycle_pkg::CYC_BEGIN :
                      (controllerStart & ~selectsActive) ? sram_cycle_pkg::CYC_DESELECT :
                      controllerStart ? sram_cycle_pkg::CYC_BEGIN :
                      (strobesIdle & ~burst_advance_n) ? sram_cycle_pkg::CYC_CONTINUE :
                      sram_cycle_pkg::CYC_SUSPEND;

  assign beginWrite = controllerStart & ~writeQualifier_n;
  assign burstWrite = strobesIdle & ~writeQualifier_n;
  assign nextWrite = beginWrite | burstWrite;

  // ********************************************************
  // Burst counter
  // ********************************************************
  burst_if burstLink ();

  logic isBegin;
  logic isContinue;
  logic isSuspend;
  logic [sram_cycle_pkg::ADDR_W-1:0] burstBase;
  logic [sram_cycle_pkg::ADDR_W-1:0] next_coreAddr;

  assign isBegin = (next_cycle == sram_cycle_pkg::CYC_BEGIN);
  assign isContinue = (next_cycle == sram_cycle_pkg::CYC_CONTINUE);
  assign isSuspend = (next_cycle == sram_cycle_pkg::CYC_SUSPEND);

  assign burstLink.load = isBegin;
  assign burstLink.advance = isContinue;
  assign burstLink.linearOrder = ~orderSync;
  assign burstLink.startBits = address[sram_cycle_pkg::BURST_W-1:0];

  burst_counter counterUnit (
    .clock(clock),
    .srst(srst),
    .clockEnable(clockEnable),
    .link(burstLink.counter)
  );

  always_comb begin
    next_coreAddr = coreAddr;
    unique case (next_cycle)
      sram_cycle_pkg::CYC_BEGIN: begin
        next_coreAddr = address;
      end
      sram_cycle_pkg::CYC_CONTINUE: begin
        next_coreAddr = {burstBase[sram_cycle_pkg::ADDR_W-1:sram_cycle_pkg::BURST_W], burstLink.nextBits};
      end
      sram_cycle_pkg::CYC_SUSPEND: begin
        next_coreAddr = {burstBase[sram_cycle_pkg::ADDR_W-1:sram_cycle_pkg::BURST_W], burstLink.curBits};
      end
      default: begin
        next_coreAddr = coreAddr;
      end
    endcase
  end

  // ********************************************************
  // Cycle registers
  // ********************************************************
  logic readDrive;
  logic next_readDrive;
  logic [sram_cycle_pkg::LANES-1:0] next_writeLanes;
  logic dataCycle;

  assign dataCycle = isBegin | isContinue | isSuspend;
  assign next_readDrive = dataCycle & ~nextWrite;
  assign next_writeLanes = (dataCycle & nextWrite) ? laneWrites : sram_cycle_pkg::LANES_NONE;

  always_ff @(posedge clock) begin
    if (srst) begin
      cycleKind <= sram_cycle_pkg::CYC_IDLE;
      burstBase <= sram_cycle_pkg::ADDR_RESET;
      coreAddr <= sram_cycle_pkg::ADDR_RESET;
      readDrive <= 1'b0;
      coreRead <= 1'b0;
      coreWriteLanes <= sram_cycle_pkg::LANES_NONE;
      coreWriteData <= sram_cycle_pkg::DATA_RESET;
      sleeping <= 1'b0;
    end else if (clockEnable) begin
      cycleKind <= next_cycle;
      sleeping <= sleepSync;
      readDrive <= next_readDrive;
      coreRead <= next_readDrive;
      coreWriteLanes <= next_writeLanes;
      coreAddr <= next_coreAddr;
      if (isBegin) begin
        burstBase <= address;
      end
      if (dataCycle & nextWrite) begin
        coreWriteData <= dqIn;
      end
    end
  end

  // ********************************************************
  // Data pin drivers
  // ********************************************************
  // Output enable and sleep are asynchronous pins and gate the drivers directly
  logic driveData;

  assign driveData = readDrive & ~outputEnable_n & ~sleep_request;
  assign dqOe = {sram_cycle_pkg::DATA_W{driveData}};
  assign dqOut = coreReadData;

endmodule

`default_nettype wire

// file: logic/sram_cycle_pkg.sv
// Shared widths, reset values and cycle kinds of the burst SRAM cycle decoder
`default_nettype none

package sram_cycle_pkg;

  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 19;
  localparam int BURST_W = 2;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_DESELECT,
    CYC_BEGIN,
    CYC_CONTINUE,
    CYC_SUSPEND,
    CYC_SLEEP
  } cycle_t;

endpackage

`default_nettype wire

// file: logic/burst_if.sv
// Link between the cycle decoder and the 2-bit burst counter
`timescale 1ns/1ns
`default_nettype none

interface burst_if;
  logic load;
  logic advance;
  logic linearOrder;
  logic [sram_cycle_pkg::BURST_W-1:0] startBits;
  logic [sram_cycle_pkg::BURST_W-1:0] curBits;
  logic [sram_cycle_pkg::BURST_W-1:0] nextBits;

  modport decoder (
    output load,
    output advance,
    output linearOrder,
    output startBits,
    input curBits,
    input nextBits
  );

  modport counter (
    input load,
    input advance,
    input linearOrder,
    input startBits,
    output curBits,
    output nextBits
  );
endinterface

`default_nettype wire

// file: logic/burst_counter.sv
// Two-bit wraparound burst counter with linear or interleaved order
`timescale 1ns/1ns
`default_nettype none

module burst_counter (
  input wire logic clock,
  input wire logic srst,
  input wire logic clockEnable,
  burst_if.counter link
);

  logic [sram_cycle_pkg::BURST_W-1:0] start;
  logic [sram_cycle_pkg::BURST_W-1:0] count;
  logic [sram_cycle_pkg::BURST_W-1:0] countPlus;

  // ********************************************************
  // Order mapping
  // ********************************************************
  function automatic logic [sram_cycle_pkg::BURST_W-1:0] orderBits(
    input logic linear,
    input logic [sram_cycle_pkg::BURST_W-1:0] first,
    input logic [sram_cycle_pkg::BURST_W-1:0] step
  );
    orderBits = linear ? sram_cycle_pkg::BURST_W'(first + step) : (first ^ step);
  endfunction

  assign countPlus = sram_cycle_pkg::BURST_W'(count + sram_cycle_pkg::BURST_STEP);
  assign link.curBits = orderBits(link.linearOrder, start, count);
  assign link.nextBits = orderBits(link.linearOrder, start, countPlus);

  // ********************************************************
  // Counter state
  // ********************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      start <= sram_cycle_pkg::BURST_ZERO;
      count <= sram_cycle_pkg::BURST_ZERO;
    end else if (clockEnable) begin
      if (link.load) begin
        start <= link.startBits;
        count <= sram_cycle_pkg::BURST_ZERO;
      end else if (link.advance) begin
        count <= countPlus;
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/sram_cycle_chk.sv
// Port-level assertions of the burst SRAM cycle decoder
`timescale 1ns/1ns
`default_nettype none

module sram_cycle_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic clockEnable,
  input wire logic primary_select_n,
  input wire logic expansion_select_high,
  input wire logic expansion_select_n,
  input wire logic sleep_request,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic lane_a_write_n,
  input wire logic lane_b_write_n,
  input wire logic lane_c_write_n,
  input wire logic lane_d_write_n,
  input wire logic outputEnable_n,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] dqOe,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] coreAddr,
  input wire logic [sram_cycle_pkg::LANES-1:0] coreWriteLanes,
  input wire logic coreRead,
  input wire sram_cycle_pkg::cycle_t cycleKind
);
  // ****
  // Awake: sleep pin low long enough for its synchroniser to clear
  // ****
  logic [1:0] quiet;
  wire logic awake;
  wire logic sel;
  wire logic hold;
  wire logic [3:0] laneN;
  always_ff @(posedge clock) begin
    if (srst || sleep_request) quiet <= 2'h0;
    else if (clockEnable && quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  assign awake = quiet == 2'h3 && !sleep_request;
  assign sel = !primary_select_n && expansion_select_high && !expansion_select_n;
  assign hold = processor_addr_strobe_n && controller_addr_strobe_n;
  assign laneN = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
  default clocking @(posedge clock); endclocking
  default disable iff (srst || !clockEnable);
  sequence s_ctrl_write;
    awake && sel && processor_addr_strobe_n && !controller_addr_strobe_n && !global_write_n;
  endsequence
  sequence s_write_done;
    cycleKind == sram_cycle_pkg::CYC_BEGIN && coreWriteLanes == sram_cycle_pkg::LANES_ALL && !coreRead;
  endsequence
  a_deselect_quiet: assert property (awake && primary_select_n && !controller_addr_strobe_n |=>
    cycleKind == sram_cycle_pkg::CYC_DESELECT && !coreRead && coreWriteLanes == 4'h0) else $error("deselect not idle");
  a_expansion_off: assert property (awake && !primary_select_n && !expansion_select_high &&
    !processor_addr_strobe_n |=> cycleKind == sram_cycle_pkg::CYC_DESELECT) else $error("expansion off not deselect");
  a_upper_select_off: assert property (awake && !primary_select_n && expansion_select_n &&
    !processor_addr_strobe_n |=> cycleKind == sram_cycle_pkg::CYC_DESELECT) else $error("upper select off not deselect");
  a_proc_start_read: assert property (awake && sel && !processor_addr_strobe_n |=>
    cycleKind == sram_cycle_pkg::CYC_BEGIN && coreRead && coreWriteLanes == 4'h0) else $error("processor start not read");
  a_ctrl_write: assert property (s_ctrl_write |=> s_write_done) else $error("controller write wrong");
  a_lane_write: assert property (awake && hold && global_write_n && !byte_write_gate_n |=>
    coreWriteLanes == ~$past(laneN)) else $error("lane strobes wrong");
  a_read_idle: assert property (awake && hold && global_write_n && byte_write_gate_n |=>
    coreRead && coreWriteLanes == 4'h0) else $error("ungated cycle not read");
  a_suspend_hold: assert property (awake && hold && burst_advance_n |=>
    cycleKind == sram_cycle_pkg::CYC_SUSPEND && $stable(coreAddr)) else $error("suspend moved address");
  a_continue_step: assert property (awake && hold && !burst_advance_n |=>
    coreAddr[18:2] == $past(coreAddr[18:2]) && coreAddr[1:0] != $past(coreAddr[1:0])) else $error("continue step wrong");
  a_oe_release: assert property (outputEnable_n || sleep_request |-> dqOe == '0) else $error("pins driven");
  a_write_mask: assert property (coreWriteLanes != 4'h0 |-> dqOe == '0) else $error("pins driven in write");
  a_read_drive: assert property (coreRead && !outputEnable_n && !sleep_request |-> dqOe == '1) else $error("read not driven");
endmodule

`default_nettype wire

// file: verification/host_model.sv
// Host side: strobes, selects, output enable and data bus per requested cycle
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input wire logic [2:0] op,
  input wire logic oeReq_n,
  input wire logic writeQual_n,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] wrData,
  output logic primary_select_n,
  output logic expansion_select_high,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  output logic outputEnable_n,
  output logic [sram_cycle_pkg::DATA_W-1:0] dqIn
);
  // ****
  // Ops: 0 deselect, 1 processor start, 2 controller start, 3 continue, 4 suspend, 5 expansion off
  // ****
  logic writing;
  assign writing = !writeQual_n && op inside {3'h2, 3'h3, 3'h4};
  assign primary_select_n = op == 3'h0;
  // Expansion-off op turns off either the high select or, with the bench, the low one
  assign expansion_select_high = op != 3'h5 || wrData[0];
  assign processor_addr_strobe_n = !(op == 3'h1 || op == 3'h5);
  assign controller_addr_strobe_n = op > 3'h2;
  assign burst_advance_n = op != 3'h3;
  assign outputEnable_n = oeReq_n || writing;
  // Released bus shows the inverse, never a stale copy
  assign dqIn = writing ? wrData : ~wrData;
endmodule

`default_nettype wire

// file: verification/sync_burst_sram_cycle_control_tb.sv
// Self-checking bench of the burst SRAM cycle decoder
`timescale 1ns/1ns
`default_nettype none

module sync_burst_sram_cycle_control_tb;
  logic clock, srst, clockEnable, sleep_request, expansion_select_n, global_write_n, byte_write_gate_n;
  logic lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n, burstOrderSelect, oeReq_n, writeQual_n;
  logic primary_select_n, expansion_select_high, processor_addr_strobe_n, controller_addr_strobe_n;
  logic burst_advance_n, outputEnable_n, coreRead, sleeping, prevRd;
  logic [2:0] op;
  logic [1:0] start, step;
  logic [sram_cycle_pkg::ADDR_W-1:0] address, expAddr, coreAddr;
  logic [sram_cycle_pkg::DATA_W-1:0] wrData, coreReadData, dqIn, dqOut, dqOe, coreWriteData;
  logic [sram_cycle_pkg::LANES-1:0] coreWriteLanes, lanes;
  sram_cycle_pkg::cycle_t cycleKind;
  int err_count = 0, compares = 0, ticks = 0;

  sync_burst_sram_cycle_control u_dut (.clock, .srst, .clockEnable, .primary_select_n, .expansion_select_high,
    .expansion_select_n, .sleep_request, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .global_write_n, .byte_write_gate_n, .lane_a_write_n, .lane_b_write_n, .lane_c_write_n, .lane_d_write_n,
    .burstOrderSelect, .outputEnable_n, .address, .dqIn, .coreReadData, .dqOut, .dqOe, .coreAddr,
    .coreWriteLanes, .coreWriteData, .coreRead, .cycleKind, .sleeping);
  host_model u_host (.op, .oeReq_n, .writeQual_n, .wrData, .primary_select_n, .expansion_select_high,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .outputEnable_n, .dqIn);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 1000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****
  // Checking helpers
  // ****
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic sram_cycle_pkg::cycle_t kind_of(input logic [2:0] o);
    case (o)
      3'h1, 3'h2: return sram_cycle_pkg::CYC_BEGIN;
      3'h3: return sram_cycle_pkg::CYC_CONTINUE;
      3'h4: return sram_cycle_pkg::CYC_SUSPEND;
      default: return sram_cycle_pkg::CYC_DESELECT;
    endcase
  endfunction

  task automatic cyc(input logic [2:0] o);
    logic rd;
    op = o;
    address = 19'($urandom);
    wrData = {4'($urandom), $urandom};
    expansion_select_n = o == 3'h5 && wrData[0];
    coreReadData = ~wrData;
    oeReq_n = 1'($urandom);
    {global_write_n, byte_write_gate_n, lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = 6'($urandom);
    lanes = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
    writeQual_n = global_write_n && (byte_write_gate_n || lanes == 4'hF);
    rd = o == 3'h1 || (o inside {3'h2, 3'h3, 3'h4} && writeQual_n);
    lanes = (rd || o == 3'h0 || o == 3'h5) ? 4'h0 : !global_write_n ? 4'hF : ~lanes;
    if (o == 3'h1 || o == 3'h2) begin
      expAddr = address;
      start = address[1:0];
      step = 2'h0;
    end else if (o == 3'h3) begin
      step = step + 2'h1;
      expAddr[1:0] = burstOrderSelect ? start ^ step : start + step;
    end
    #49;
    chk("oe live", {36{prevRd && !outputEnable_n}}, dqOe);
    @(posedge clock);
    #1;
    prevRd = rd;
    chk("kind", kind_of(o), cycleKind);
    chk("addr", expAddr, coreAddr);
    chk("lanes", lanes, coreWriteLanes);
    chk("read", rd, coreRead);
    chk("oe", {36{rd && !oeReq_n}}, dqOe);
    chk("dout", coreReadData, dqOut);
    if (lanes != 4'h0) chk("wdata", wrData, coreWriteData);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {srst, clockEnable, sleep_request, expansion_select_n, burstOrderSelect, prevRd} = 6'b110000;
    {oeReq_n, writeQual_n, global_write_n, byte_write_gate_n, op} = 7'h7F;
    {lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n} = 4'hF;
    {address, wrData, coreReadData, expAddr} = '0;
    void'($urandom(32'h39C2D193));
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    op = 3'h0;
    chk("reset kind", sram_cycle_pkg::CYC_IDLE, cycleKind);
    for (int pass = 0; pass < 2; pass++) begin
      burstOrderSelect = pass[0];
      repeat (3) cyc(3'h0);
      cyc(3'h1);
      repeat (60) cyc(3'($urandom_range(5)));
      op = 3'h0;
      sleep_request = 1'b1;
      oeReq_n = 1'b0;
      #49;
      chk("oe asleep", 64'h0, dqOe);
      repeat (2) @(posedge clock);
      #1;
      op = 3'h1;
      repeat (2) @(posedge clock);
      #1;
      chk("sleep kind", sram_cycle_pkg::CYC_SLEEP, cycleKind);
      chk("sleep addr", expAddr, coreAddr);
      chk("sleep flag", 1'b1, sleeping);
      op = 3'h0;
      sleep_request = 1'b0;
      prevRd = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("awake flag", 1'b0, sleeping);
      clockEnable = 1'b0;
      op = 3'h3;
      repeat (3) @(posedge clock);
      #1;
      chk("frozen kind", sram_cycle_pkg::CYC_DESELECT, cycleKind);
      chk("frozen addr", expAddr, coreAddr);
      clockEnable = 1'b1;
      cyc(3'h3);
      $display("test done: burst order %0d", pass);
    end
    report_and_stop();
  end
endmodule

bind sync_burst_sram_cycle_control sram_cycle_chk u_chk (.clock, .srst, .clockEnable, .primary_select_n,
  .expansion_select_high,
  .expansion_select_n, .sleep_request, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
  .global_write_n, .byte_write_gate_n, .lane_a_write_n, .lane_b_write_n, .lane_c_write_n, .lane_d_write_n,
  .outputEnable_n, .dqOe, .coreAddr, .coreWriteLanes, .coreRead, .cycleKind);

`default_nettype wire
